// >>> hdl/eis_fifo.sv
// Byte FIFO in the data path between register map and store.
// Assumes the same clock and reset as the sequencer.
`timescale 1ns/1ps
`default_nettype none
module eis_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic do_wr, do_rd;
   // Handshakes and pointer updates
   always_comb
   begin
      do_wr = in_valid && in_ready;
      do_rd = out_valid && out_ready;
      wp_nxt = do_wr ? ((wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1) : wp_r;
      rp_nxt = do_rd ? ((rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1) : rp_r;
      cnt_nxt = cnt_r + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
   end
   // Storage and pointers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
      if (do_wr)
         mem_r[wp_r] <= in_data;
   end
   assign in_ready = (cnt_r != (AW + 1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
endmodule
`default_nettype wire

// >>> hdl/eis_pkg.sv
// Constants for the configuration store instruction sequencer.
// Assumes one system clock and a synchronous active-high reset.
// Behaviour
// - Store holds 2048 bytes, pointer spans all
// - 48-byte scratch pad at 0x0E10 to 0x0E3F
// - Control registers 0x0E00-0x0E03 start transfers only when idle
// - Power-up download selected by upper config pins
// - Upload saves registers, download restores them
// - Data instruction 0x00-0x7F moves value+1 bytes
// - Address MSB in D7 of first (upper) byte
// - Block transfers step upward from start address
// - 0x80 in download issues soft I/O update
// - 0xA0 in download starts clock calibration
// - 0xA1 in download emits distribution sync pulse
// - 0xB1-0xCF are conditions 1-31, 0xB0 null
// - Upload pause resets pad pointer, keeps store pointer
// - All instructions recognised, pause only in upload
// - Upload end resets both pointers, goes idle
// - Download end resets store pointer, goes idle
// - Upload appends one-byte checksum to each block
// - Download checksum mismatch sets fault flag
// - All checksums matching sets completion flag
// - Upload after pause appends behind previous sequence
// - Load command runs store instructions until end
// - Active condition gates execution when tags exist
package eis_pkg;
   localparam int STORE_BYTES = 2048;
   localparam int STORE_AW = 11;
   localparam int PAD_BYTES = 48;
   localparam int PAD_AW = 6;
   localparam logic [15:0] ADDR_CTRL_FIRST = 16'h0e00;
   localparam logic [15:0] ADDR_CTRL_LAST = 16'h0e03;
   localparam logic [15:0] ADDR_PAD_FIRST = 16'h0e10;
   localparam logic [15:0] ADDR_PAD_LAST = 16'h0e3f;
   localparam logic [7:0] OP_DATA_MAX = 8'h7f;
   localparam logic [7:0] OP_IO_UPDATE = 8'h80;
   localparam logic [7:0] OP_CALIBRATE = 8'ha0;
   localparam logic [7:0] OP_DIST_SYNC = 8'ha1;
   localparam logic [7:0] OP_COND_NULL = 8'hb0;
   localparam logic [7:0] OP_COND_LAST = 8'hcf;
   localparam logic [7:0] OP_PAUSE = 8'hfe;
   localparam logic [7:0] OP_END = 8'hff;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 8;
   localparam int CLK_MHZ = 100;
   localparam int GAP_US = 10;
   localparam int GAP_CYC = GAP_US * CLK_MHZ;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_FETCH = 4'b0001,
      ST_DECODE = 4'b0010,
      ST_ADDR_HI = 4'b0011,
      ST_ADDR_LO = 4'b0100,
      ST_MOVE = 4'b0101,
      ST_CSUM = 4'b0110,
      ST_STORE_OP = 4'b0111,
      ST_DRAIN = 4'b1000
   } eis_state_t;
endpackage

// >>> hdl/eis_sequencer.sv
// Instruction sequencer moving bytes between store and register map.
// Assumes store and register map answer reads in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module eis_sequencer (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Control bits
   input wire logic WRITE_EN,
   input wire logic SAVE_CMD,
   input wire logic LOAD_CMD,
   input wire logic [4:0] COND_REG,
   input wire logic [4:0] BOOT_CONDITION_PINS,
   // Scratch pad read port
   output logic [5:0] PAD_ADDR,
   input wire logic [7:0] PAD_RDATA,
   // Store port
   output logic [10:0] STORE_ADDR,
   input wire logic [7:0] STORE_RDATA,
   output logic STORE_WE,
   output logic [7:0] STORE_WDATA,
   // Register map port
   output logic [15:0] MAP_ADDR,
   input wire logic [7:0] MAP_RDATA,
   output logic MAP_WE,
   output logic [7:0] MAP_WDATA,
   // Events and status
   output logic IO_UPDATE,
   output logic CAL_START,
   output logic DIST_SYNC,
   output logic BUSY,
   output logic FAULT,
   output logic DONE
);
   eis_pkg::eis_state_t st_r, st_nxt;
   logic upl_r, upl_nxt; // Upload mode
   logic [5:0] pp_r, pp_nxt; // Scratch pad pointer
   logic [10:0] sp_r, sp_nxt; // Store pointer
   logic [15:0] ma_r, ma_nxt; // Register map address
   logic [7:0] len_r, len_nxt; // Bytes left minus one
   logic [7:0] op_r, op_nxt; // Current instruction
   logic [7:0] cs_r, cs_nxt; // Running checksum
   logic [31:1] tag_r, tag_nxt; // Condition tag board
   logic [4:0] pins_r, pins_nxt; // Captured pin state
   logic boot_r, boot_nxt; // Boot download pending
   logic bad_r, bad_nxt; // Mismatch seen
   logic io_nxt, cal_nxt, sync_nxt, flt_nxt, done_nxt;
   logic swe_nxt, mwe_nxt;
   logic [7:0] swd_nxt, mwd_nxt;
   logic [4:0] cond;
   logic [7:0] byte_in;
   logic exec;
   // Upload FIFO between map reads and store writes
   logic f_iv, f_ir, f_ov, f_or;
   logic [7:0] f_od;
   eis_fifo #(.W(eis_pkg::FIFO_W), .D(eis_pkg::FIFO_D)) u_fifo (
      .clk(CLK),
      .rst(RST),
      .in_valid(f_iv),
      .in_ready(f_ir),
      .in_data(MAP_RDATA),
      .out_valid(f_ov),
      .out_ready(f_or),
      .out_data(f_od)
   );
   // Next-state logic
   always_comb
   begin
      st_nxt = st_r;
      upl_nxt = upl_r;
      pp_nxt = pp_r;
      sp_nxt = sp_r;
      ma_nxt = ma_r;
      len_nxt = len_r;
      op_nxt = op_r;
      cs_nxt = cs_r;
      tag_nxt = tag_r;
      pins_nxt = pins_r;
      boot_nxt = 1'b0;
      bad_nxt = bad_r;
      io_nxt = 1'b0;
      cal_nxt = 1'b0;
      sync_nxt = 1'b0;
      flt_nxt = FAULT;
      done_nxt = DONE;
      swe_nxt = 1'b0;
      swd_nxt = 8'h00;
      mwe_nxt = 1'b0;
      mwd_nxt = 8'h00;
      f_iv = 1'b0;
      f_or = 1'b0;
      // Register value wins, else captured pins
      cond = (COND_REG != 5'h00) ? COND_REG : pins_r;
      byte_in = upl_r ? PAD_RDATA : STORE_RDATA;
      // Gate execution by the tag board
      exec = upl_r || (cond == 5'h00) || (tag_r == '0) || tag_r[cond];
      case (st_r)
         eis_pkg::ST_IDLE:
         begin
            if (boot_r && BOOT_CONDITION_PINS != 5'h00)
            begin
               upl_nxt = 1'b0;
               st_nxt = eis_pkg::ST_FETCH;
               tag_nxt = '0;
               bad_nxt = 1'b0;
            end
            else if (SAVE_CMD && WRITE_EN)
            begin
               upl_nxt = 1'b1;
               st_nxt = eis_pkg::ST_FETCH;
            end
            else if (LOAD_CMD)
            begin
               upl_nxt = 1'b0;
               st_nxt = eis_pkg::ST_FETCH;
               tag_nxt = '0;
               bad_nxt = 1'b0;
               flt_nxt = 1'b0;
               done_nxt = 1'b0;
            end
         end
         eis_pkg::ST_FETCH:
         begin
            op_nxt = byte_in;
            st_nxt = eis_pkg::ST_DECODE;
            if (upl_r)
               pp_nxt = (pp_r == 6'(eis_pkg::PAD_BYTES - 1)) ? 6'h00 : pp_r + 6'h01;
            else
               sp_nxt = sp_r + 11'h001;
         end
         eis_pkg::ST_DECODE:
         begin
            st_nxt = eis_pkg::ST_FETCH;
            if (op_r <= eis_pkg::OP_DATA_MAX)
            begin
               len_nxt = op_r;
               cs_nxt = 8'h00;
               st_nxt = upl_r ? eis_pkg::ST_STORE_OP : eis_pkg::ST_ADDR_HI;
            end
            else if (op_r == eis_pkg::OP_END)
            begin
               sp_nxt = 11'h000;
               pp_nxt = 6'h00;
               st_nxt = eis_pkg::ST_IDLE;
               if (!upl_r)
               begin
                  flt_nxt = bad_r;
                  done_nxt = !bad_r;
               end
               else
               begin
                  // End byte kept so a later download stops here
                  swe_nxt = 1'b1;
                  swd_nxt = op_r;
               end
            end
            else if (op_r == eis_pkg::OP_PAUSE && upl_r)
            begin
               pp_nxt = 6'h00;
               st_nxt = eis_pkg::ST_IDLE;
            end
            else if (upl_r)
            begin
               // Other instructions copied verbatim
               swe_nxt = 1'b1;
               swd_nxt = op_r;
               sp_nxt = sp_r + 11'h001;
            end
            else if (op_r >= eis_pkg::OP_COND_NULL && op_r <= eis_pkg::OP_COND_LAST)
            begin
               if (op_r == eis_pkg::OP_COND_NULL)
                  tag_nxt = '0;
               else
                  tag_nxt[5'(op_r - eis_pkg::OP_COND_NULL)] = 1'b1;
            end
            else if (exec)
            begin
               io_nxt = (op_r == eis_pkg::OP_IO_UPDATE);
               cal_nxt = (op_r == eis_pkg::OP_CALIBRATE);
               sync_nxt = (op_r == eis_pkg::OP_DIST_SYNC);
            end
         end
         eis_pkg::ST_STORE_OP:
         begin
            swe_nxt = 1'b1;
            swd_nxt = op_r;
            sp_nxt = sp_r + 11'h001;
            st_nxt = eis_pkg::ST_ADDR_HI;
         end
         eis_pkg::ST_ADDR_HI:
         begin
            // First byte carries the high bits
            ma_nxt[15:8] = byte_in;
            st_nxt = eis_pkg::ST_ADDR_LO;
            if (upl_r)
            begin
               swe_nxt = 1'b1;
               swd_nxt = byte_in;
               pp_nxt = pp_r + 6'h01;
            end
            sp_nxt = sp_r + 11'h001;
         end
         eis_pkg::ST_ADDR_LO:
         begin
            ma_nxt[7:0] = byte_in;
            st_nxt = eis_pkg::ST_MOVE;
            if (upl_r)
            begin
               swe_nxt = 1'b1;
               swd_nxt = byte_in;
               pp_nxt = pp_r + 6'h01;
            end
            sp_nxt = sp_r + 11'h001;
         end
         eis_pkg::ST_MOVE:
         begin
            if (upl_r)
            begin
               // Map reads pushed into the FIFO
               f_iv = 1'b1;
               if (f_ir)
               begin
                  cs_nxt = cs_r + MAP_RDATA;
                  ma_nxt = ma_r + 16'h0001;
                  len_nxt = len_r - 8'h01;
                  if (len_r == 8'h00)
                     st_nxt = eis_pkg::ST_DRAIN;
               end
            end
            else
            begin
               mwe_nxt = exec;
               mwd_nxt = STORE_RDATA;
               cs_nxt = cs_r + STORE_RDATA;
               ma_nxt = ma_r + 16'h0001;
               sp_nxt = sp_r + 11'h001;
               len_nxt = len_r - 8'h01;
               if (len_r == 8'h00)
                  st_nxt = eis_pkg::ST_CSUM;
            end
         end
         eis_pkg::ST_DRAIN:
         begin
            if (!f_ov)
               st_nxt = eis_pkg::ST_CSUM;
         end
         eis_pkg::ST_CSUM:
         begin
            sp_nxt = sp_r + 11'h001;
            st_nxt = eis_pkg::ST_FETCH;
            if (upl_r)
            begin
               swe_nxt = 1'b1;
               swd_nxt = cs_r;
            end
            else if (exec && STORE_RDATA != cs_r)
               bad_nxt = 1'b1;
         end
         default:
            st_nxt = eis_pkg::ST_IDLE;
      endcase
      // FIFO drains into the store while moving or draining
      if (upl_r && (st_r == eis_pkg::ST_MOVE || st_r == eis_pkg::ST_DRAIN) && f_ov)
      begin
         f_or = 1'b1;
         swe_nxt = 1'b1;
         swd_nxt = f_od;
         sp_nxt = sp_r + 11'h001;
      end
   end
   // State registers
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         st_r <= eis_pkg::ST_IDLE;
         upl_r <= 1'b0;
         pp_r <= 6'h00;
         sp_r <= 11'h000;
         ma_r <= 16'h0000;
         len_r <= 8'h00;
         op_r <= 8'h00;
         cs_r <= 8'h00;
         tag_r <= '0;
         pins_r <= 5'h00;
         boot_r <= 1'b1;
         bad_r <= 1'b0;
         IO_UPDATE <= 1'b0;
         CAL_START <= 1'b0;
         DIST_SYNC <= 1'b0;
         FAULT <= 1'b0;
         DONE <= 1'b0;
         STORE_WE <= 1'b0;
         STORE_WDATA <= 8'h00;
         MAP_WE <= 1'b0;
         MAP_WDATA <= 8'h00;
      end
      else
      begin
         st_r <= st_nxt;
         upl_r <= upl_nxt;
         pp_r <= pp_nxt;
         sp_r <= sp_nxt;
         ma_r <= ma_nxt;
         len_r <= len_nxt;
         op_r <= op_nxt;
         cs_r <= cs_nxt;
         tag_r <= tag_nxt;
         // Pins caught in first cycle after reset
         pins_r <= boot_r ? BOOT_CONDITION_PINS : pins_nxt;
         boot_r <= boot_nxt;
         bad_r <= bad_nxt;
         IO_UPDATE <= io_nxt;
         CAL_START <= cal_nxt;
         DIST_SYNC <= sync_nxt;
         FAULT <= flt_nxt;
         DONE <= done_nxt;
         STORE_WE <= swe_nxt;
         STORE_WDATA <= swd_nxt;
         MAP_WE <= mwe_nxt;
         MAP_WDATA <= mwd_nxt;
      end
   end
   // Write addresses follow the pointers one cycle late
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         PAD_ADDR <= 6'h00;
         STORE_ADDR <= 11'h000;
         MAP_ADDR <= 16'h0000;
         BUSY <= 1'b0;
      end
      else
      begin
         PAD_ADDR <= pp_nxt;
         STORE_ADDR <= swe_nxt ? sp_r : sp_nxt;
         MAP_ADDR <= mwe_nxt ? ma_r : ma_nxt;
         BUSY <= (st_nxt != eis_pkg::ST_IDLE);
      end
   end
   // Busy tracks the controller leaving idle
   property p_busy;
      @(posedge CLK) disable iff (RST)
      (st_r != eis_pkg::ST_IDLE) |-> BUSY;
   endproperty
   a_busy: assert property (p_busy) else $error("busy low while active");
   property p_iou;
      @(posedge CLK) disable iff (RST)
      (st_r == eis_pkg::ST_DECODE && !upl_r && exec && op_r == eis_pkg::OP_IO_UPDATE)
      |=> IO_UPDATE;
   endproperty
   a_iou: assert property (p_iou) else $error("io update missing");
   property p_cal;
      @(posedge CLK) disable iff (RST)
      CAL_START |-> $past(op_r) == eis_pkg::OP_CALIBRATE && !$past(upl_r);
   endproperty
   a_cal: assert property (p_cal) else $error("bad calibrate pulse");
   property p_sync;
      @(posedge CLK) disable iff (RST)
      DIST_SYNC |-> $past(op_r) == eis_pkg::OP_DIST_SYNC && !$past(upl_r);
   endproperty
   a_sync: assert property (p_sync) else $error("bad sync pulse");
   property p_end;
      @(posedge CLK) disable iff (RST)
      (st_r == eis_pkg::ST_DECODE && op_r == eis_pkg::OP_END)
      |=> sp_r == 11'h000 && st_r == eis_pkg::ST_IDLE;
   endproperty
   a_end: assert property (p_end) else $error("end did not reset pointer");
   property p_pause;
      @(posedge CLK) disable iff (RST)
      (st_r == eis_pkg::ST_DECODE && upl_r && op_r == eis_pkg::OP_PAUSE)
      |=> pp_r == 6'h00 && $stable(sp_r) && !STORE_WE;
   endproperty
   a_pause: assert property (p_pause) else $error("pause handling wrong");
   property p_null;
      @(posedge CLK) disable iff (RST)
      (st_r == eis_pkg::ST_DECODE && !upl_r && op_r == eis_pkg::OP_COND_NULL)
      |=> tag_r == '0;
   endproperty
   a_null: assert property (p_null) else $error("null condition kept tags");
   property p_flags;
      @(posedge CLK) disable iff (RST)
      !(FAULT && DONE);
   endproperty
   a_flags: assert property (p_flags) else $error("fault and done both set");
endmodule
`default_nettype wire

// >>> testbench/eis_far_model.sv
// Far-side model: scratch pad, configuration store and register map.
// Assumes the sequencer reads combinationally and writes on the clock.
`timescale 1ns/1ps
`default_nettype none
module eis_far_model (
   // Clock
   input wire logic clk,
   // Scratch pad
   input wire logic [5:0] pad_addr,
   output logic [7:0] pad_rdata,
   // Store
   input wire logic [10:0] store_addr,
   output logic [7:0] store_rdata,
   input wire logic store_we,
   input wire logic [7:0] store_wdata,
   // Register map
   input wire logic [15:0] map_addr,
   output logic [7:0] map_rdata,
   input wire logic map_we,
   input wire logic [7:0] map_wdata
);
   logic [7:0] pad [0:47]; // Instruction pad
   logic [7:0] store [0:2047]; // Nonvolatile bytes
   logic [7:0] map [0:65535]; // Device settings
   // Same-cycle reads; past the pad's end a junk pattern
   assign pad_rdata = (pad_addr < 6'd48) ? pad[pad_addr] : 8'h5a;
   assign store_rdata = store[store_addr];
   assign map_rdata = map[map_addr];
   // Writes land on the clock edge
   always @(posedge clk)
   begin
      if (store_we)
      begin
         store[store_addr] <= store_wdata;
      end
      if (map_we)
      begin
         map[map_addr] <= map_wdata;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the instruction sequencer.
// Assumes the far-side model answers store, pad and map accesses.
`timescale 1ns/1ps
`default_nettype none
module tb;
   // Row of a single-byte instruction case
   typedef struct packed {
      logic [7:0] op;
      logic io;
      logic cal;
      logic sync;
   } eis_row_t;
   eis_row_t rows [7] = '{'{8'h80, 1'b1, 1'b0, 1'b0}, '{8'ha0, 1'b0, 1'b1, 1'b0},
      '{8'ha1, 1'b0, 1'b0, 1'b1}, '{8'hb0, 1'b0, 1'b0, 1'b0}, '{8'hb5, 1'b0, 1'b0, 1'b0},
      '{8'hcf, 1'b0, 1'b0, 1'b0}, '{8'hfe, 1'b0, 1'b0, 1'b0}};
   // Store image after pause-then-end uploads
   logic [7:0] up_exp [14] = '{8'h01, 8'h01, 8'h23, 8'ha5, 8'h3c, 8'he1, 8'h80,
      8'h00, 8'h01, 8'h23, 8'ha5, 8'ha5, 8'hff, 8'h5a};
   logic clk, rst, write_en, save_cmd, load_cmd;
   logic [4:0] cond_reg, boot_pins;
   logic [5:0] pad_addr;
   logic [7:0] pad_rdata, store_rdata, store_wdata, map_rdata, map_wdata;
   logic [10:0] store_addr;
   logic [15:0] map_addr;
   logic store_we, map_we, io_update, cal_start, dist_sync, busy, fault, done;
   logic [7:0] io_n, cal_n, sync_n; // Event pulse counts
   int mismatches;
   int n_tests;
   // Device under test
   eis_sequencer i_dut (.CLK(clk), .RST(rst), .WRITE_EN(write_en), .SAVE_CMD(save_cmd),
      .LOAD_CMD(load_cmd), .COND_REG(cond_reg), .BOOT_CONDITION_PINS(boot_pins),
      .PAD_ADDR(pad_addr), .PAD_RDATA(pad_rdata), .STORE_ADDR(store_addr),
      .STORE_RDATA(store_rdata), .STORE_WE(store_we), .STORE_WDATA(store_wdata),
      .MAP_ADDR(map_addr), .MAP_RDATA(map_rdata), .MAP_WE(map_we), .MAP_WDATA(map_wdata),
      .IO_UPDATE(io_update), .CAL_START(cal_start), .DIST_SYNC(dist_sync),
      .BUSY(busy), .FAULT(fault), .DONE(done));
   // Far side
   eis_far_model i_far (.clk(clk), .pad_addr(pad_addr), .pad_rdata(pad_rdata),
      .store_addr(store_addr), .store_rdata(store_rdata), .store_we(store_we),
      .store_wdata(store_wdata), .map_addr(map_addr), .map_rdata(map_rdata),
      .map_we(map_we), .map_wdata(map_wdata));
   // 100 MHz clock
   always #5 clk = ~clk;
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One transfer: 1 save, 2 load, 0 none; counts pulses, then host gap
   task automatic run(input int kind);
      int n;
      logic seen;
      io_n = 8'h00;
      cal_n = 8'h00;
      sync_n = 8'h00;
      seen = 1'b0;
      n = 0;
      save_cmd = (kind == 1);
      load_cmd = (kind == 2);
      @(posedge clk);
      #1;
      save_cmd = 1'b0;
      load_cmd = 1'b0;
      while (n < 6000 && !(seen && busy === 1'b0))
      begin
         @(posedge clk);
         #1;
         io_n += 8'(io_update === 1'b1);
         cal_n += 8'(cal_start === 1'b1);
         sync_n += 8'(dist_sync === 1'b1);
         if (busy === 1'b1)
            seen = 1'b1;
         n++;
      end
      chk(8'(seen), 8'h01);
      chk(8'(busy), 8'h00);
      repeat (1000) @(posedge clk); // Host spacing between transfers
      #1;
   endtask
   // Watchdog against hangs
   initial
   begin
      repeat (40000) @(posedge clk);
      mismatches++;
      $display("Watchdog expired");
      conclude;
   end
   // Main sequence
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      write_en = 1'b0;
      save_cmd = 1'b0;
      load_cmd = 1'b0;
      cond_reg = 5'h00;
      boot_pins = 5'h00;
      mismatches = 0;
      n_tests = 0;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(8'(busy), 8'h00);
      chk(8'(fault), 8'h00);
      chk(8'(done), 8'h00);
      chk(8'({store_we, map_we}), 8'h00);
      $display("Test reset finished");
      // Single-byte instructions in download
      for (int r = 0; r < 7; r++)
      begin
         i_far.store[0] = rows[r].op;
         i_far.store[1] = 8'hff;
         run(2);
         chk(io_n, 8'(rows[r].io));
         chk(cal_n, 8'(rows[r].cal));
         chk(sync_n, 8'(rows[r].sync));
         $display("Test opcode %h finished", rows[r].op);
      end
      // Upload ending in pause, then appended upload ending in end
      for (int i = 0; i < 16; i++)
         i_far.store[i] = 8'h5a;
      i_far.map[16'h0123] = 8'ha5;
      i_far.map[16'h0124] = 8'h3c;
      i_far.pad[0] = 8'h01;
      i_far.pad[1] = 8'h01;
      i_far.pad[2] = 8'h23;
      i_far.pad[3] = 8'h80;
      i_far.pad[4] = 8'hfe;
      write_en = 1'b1;
      run(1);
      i_far.pad[0] = 8'h00;
      i_far.pad[1] = 8'h01;
      i_far.pad[2] = 8'h23;
      i_far.pad[3] = 8'hff;
      run(1);
      for (int i = 0; i < 14; i++)
         chk(i_far.store[i], up_exp[i]);
      $display("Test upload finished");
      // Download restores the map
      i_far.map[16'h0123] = 8'h00;
      i_far.map[16'h0124] = 8'h00;
      run(2);
      chk(i_far.map[16'h0123], 8'ha5);
      chk(i_far.map[16'h0124], 8'h3c);
      chk(io_n, 8'h01);
      chk(8'({fault, done}), 8'h01);
      $display("Test download finished");
      // Corrupted block raises the fault flag
      i_far.store[4] = 8'h3d;
      run(2);
      chk(8'({fault, done}), 8'h02);
      $display("Test checksum fault finished");
      // Upload after end starts from store address zero
      i_far.pad[0] = 8'ha0;
      i_far.pad[1] = 8'hff;
      run(1);
      chk(i_far.store[0], 8'ha0);
      chk(i_far.store[1], 8'hff);
      chk(i_far.store[2], 8'h23);
      $display("Test upload after end finished");
      // Save without write enable is refused
      write_en = 1'b0;
      save_cmd = 1'b1;
      @(posedge clk);
      #1;
      save_cmd = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(8'(busy), 8'h00);
      $display("Test refused save finished");
      // Condition gating: tag 3, active 2 skips, active 3 runs
      i_far.store[0] = 8'hb3;
      i_far.store[1] = 8'h00;
      i_far.store[2] = 8'h01;
      i_far.store[3] = 8'h23;
      i_far.store[4] = 8'h77;
      i_far.store[5] = 8'h77;
      i_far.store[6] = 8'hff;
      i_far.map[16'h0123] = 8'h00;
      cond_reg = 5'h02;
      run(2);
      chk(i_far.map[16'h0123], 8'h00);
      cond_reg = 5'h03;
      run(2);
      chk(i_far.map[16'h0123], 8'h77);
      $display("Test conditions finished");
      // Boot pins select an automatic download
      cond_reg = 5'h00;
      i_far.map[16'h0123] = 8'h00;
      boot_pins = 5'h03;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      run(0);
      chk(i_far.map[16'h0123], 8'h77);
      chk(8'(done), 8'h01);
      $display("Test boot download finished");
      conclude;
   end
endmodule
`default_nettype wire
